// ### scan_net_defs.svh
`ifndef SCAN_NET_DEFS_SVH
`define SCAN_NET_DEFS_SVH

// Station addressing: five bits reach stations 0 to 31.
`define ADDR_W 5
`define MASTER_ADDR 5'h00
`define FIRST_SLAVE 5'h01
`define TMO_W 16

// Request byte: command in the top three bits, station in the low five.
`define CMD_INIT 3'h1
`define CMD_POLL 3'h2
`define CMD_CFG 3'h3

// Characters of the start-up and timeout messages.
`define CHR_ZERO 8'h30
`define CHR_S 8'h53
`define CHR_T 8'h54

`endif

// ### scan_net_pkg.sv
package scan_net_pkg;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_flow_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } rx_flow_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic [4:0] addr;
        logic [7:0] data;
    } cfg_flow_t;

    typedef enum logic [2:0] {
        ST_PICK,
        ST_SEND,
        ST_WAIT,
        ST_REPORT,
        ST_CFG_HDR,
        ST_CFG_DATA
    } state_t;

endpackage : scan_net_pkg

// ### scan_net_master.sv
// How it works
// - Up to 31 slave stations, each reached by a five-bit station address.
// - Master is station zero; only addresses above zero are ever requested.
// - A configured highest slave address sets how many slaves are managed.
// - Slave data received after the search is forwarded out of the single host byte stream if that stream is free, and lost if not.
// - After reset every address up to the highest is searched once.
// - A slave answering during the search is reported as two digits and S.
// - A silent slave is reported as two digits and T.
// - After timeouts polling continues but timed-out slaves are skipped.
// - Once running, host configuration bytes are relayed to a chosen slave that is in range and still alive, and dropped otherwise.
// - All traffic runs half duplex on one shared two-wire bus.
`include "scan_net_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module scan_net_master (
    // Clock, reset and enable
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Configuration
    input wire logic [`ADDR_W-1:0] last_addr,
    input wire logic [`TMO_W-1:0] resp_wait,
    // Shared bus, byte level
    output scan_net_pkg::byte_flow_t bus_tx,
    input wire logic bus_tx_ready,
    output logic bus_drive_en,
    input wire scan_net_pkg::rx_flow_t bus_rx,
    // Host interface, byte level
    output scan_net_pkg::byte_flow_t host_tx,
    input wire logic host_tx_ready,
    input wire scan_net_pkg::cfg_flow_t host_cfg,
    output logic cfg_take,
    // Status
    output logic init_done,
    output logic [31:0] alive_map
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] mk_req(input logic [2:0] cmd, input logic [4:0] a);
        mk_req = {cmd, a};
    endfunction : mk_req

    function automatic logic [7:0] dec_digit(input logic [4:0] a, input logic tens);
        logic [4:0] t;
        t = (a >= 5'h1E) ? 5'h03 : (a >= 5'h14) ? 5'h02 : (a >= 5'h0A) ? 5'h01 : 5'h00;
        if (tens) begin
            dec_digit = `CHR_ZERO + {3'h0, t};
        end else begin
            dec_digit = `CHR_ZERO + {3'h0, 5'(a - 5'(t * 5'h0A))};
        end
    endfunction : dec_digit

    // ----------------------------------------
    // State
    // ----------------------------------------
    scan_net_pkg::state_t state_reg;
    logic [4:0] cur_addr_reg;
    logic [`TMO_W-1:0] timer_reg;
    logic [1:0] rpt_idx_reg;
    logic rpt_ok_reg;
    logic [31:0] alive_reg;
    logic init_done_reg;
    logic cfg_take_reg;
    logic bus_de_reg;
    logic req_sent_reg;
    scan_net_pkg::byte_flow_t bus_tx_reg;
    scan_net_pkg::byte_flow_t host_tx_reg;

    // ----------------------------------------
    // Decoding
    // ----------------------------------------
    wire logic bus_free = !bus_tx_reg.valid || bus_tx_ready;
    wire logic host_free = !host_tx_reg.valid || host_tx_ready;
    wire logic at_last = (cur_addr_reg >= last_addr);
    // Ascending walk that wraps back to the first slave.
    wire logic [4:0] poll_next = at_last ? `FIRST_SLAVE : 5'(cur_addr_reg + 5'h01);
    wire logic [4:0] init_next = 5'(cur_addr_reg + 5'h01);
    wire logic timed_out = (timer_reg >= resp_wait) && !bus_rx.valid;
    wire logic cfg_ok = (host_cfg.addr != `MASTER_ADDR) && (host_cfg.addr <= last_addr)
        && alive_reg[host_cfg.addr];
    wire logic cfg_byte = host_cfg.valid && bus_free && !cfg_take_reg;
    wire logic [7:0] rpt_char = (rpt_idx_reg == 2'h2) ? (rpt_ok_reg ? `CHR_S : `CHR_T)
        : dec_digit(cur_addr_reg, rpt_idx_reg == 2'h0);
    wire logic [2:0] req_cmd = init_done_reg ? `CMD_POLL : `CMD_INIT;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg <= scan_net_pkg::ST_PICK;
            cur_addr_reg <= `MASTER_ADDR;
            timer_reg <= 16'h0000;
            rpt_idx_reg <= 2'h0;
            rpt_ok_reg <= 1'b0;
            alive_reg <= 32'h0000_0000;
            init_done_reg <= 1'b0;
            cfg_take_reg <= 1'b0;
            bus_de_reg <= 1'b0;
            req_sent_reg <= 1'b0;
            bus_tx_reg <= '0;
            host_tx_reg <= '0;
        end else if (clk_en) begin
            cfg_take_reg <= 1'b0;
            if (bus_tx_reg.valid && bus_tx_ready) begin
                bus_tx_reg.valid <= 1'b0;
            end
            if (host_tx_reg.valid && host_tx_ready) begin
                host_tx_reg.valid <= 1'b0;
            end
            case (state_reg)
                scan_net_pkg::ST_PICK: begin
                    bus_de_reg <= 1'b0;
                    if (!init_done_reg) begin
                        if (at_last) begin
                            init_done_reg <= 1'b1;
                        end else begin
                            cur_addr_reg <= init_next;
                            state_reg <= scan_net_pkg::ST_SEND;
                        end
                    end else if (host_cfg.valid && !cfg_take_reg) begin
                        // A byte taken last cycle still stands on host_cfg for one cycle.
                        state_reg <= scan_net_pkg::ST_CFG_HDR;
                    end else if (last_addr != `MASTER_ADDR) begin
                        cur_addr_reg <= poll_next;
                        if (alive_reg[poll_next]) begin
                            state_reg <= scan_net_pkg::ST_SEND;
                        end
                    end
                end
                scan_net_pkg::ST_SEND: begin
                    // Hold the driver on until the request byte has left; after a relay
                    // it is already on and stays on across the last config byte.
                    if (bus_free && !req_sent_reg) begin
                        bus_tx_reg <= '{valid: 1'b1, data: mk_req(req_cmd, cur_addr_reg)};
                        bus_de_reg <= 1'b1;
                        req_sent_reg <= 1'b1;
                    end else if (req_sent_reg && bus_free) begin
                        bus_de_reg <= 1'b0;
                        req_sent_reg <= 1'b0;
                        timer_reg <= 16'h0000;
                        state_reg <= scan_net_pkg::ST_WAIT;
                    end
                end
                scan_net_pkg::ST_WAIT: begin
                    timer_reg <= 16'(timer_reg + 16'h0001);
                    if (bus_rx.valid) begin
                        timer_reg <= 16'h0000;
                        if (init_done_reg && host_free) begin
                            // No buffer: a byte the host cannot take now is lost.
                            host_tx_reg <= '{valid: 1'b1, data: bus_rx.data};
                        end
                        if (bus_rx.last && !init_done_reg) begin
                            alive_reg[cur_addr_reg] <= 1'b1;
                            rpt_ok_reg <= 1'b1;
                            rpt_idx_reg <= 2'h0;
                            state_reg <= scan_net_pkg::ST_REPORT;
                        end else if (bus_rx.last) begin
                            state_reg <= scan_net_pkg::ST_PICK;
                        end
                    end else if (timed_out) begin
                        alive_reg[cur_addr_reg] <= 1'b0;
                        rpt_ok_reg <= 1'b0;
                        rpt_idx_reg <= 2'h0;
                        state_reg <= scan_net_pkg::ST_REPORT;
                    end
                end
                scan_net_pkg::ST_REPORT: begin
                    if (host_free) begin
                        host_tx_reg <= '{valid: 1'b1, data: rpt_char};
                        rpt_idx_reg <= 2'(rpt_idx_reg + 2'h1);
                        if (rpt_idx_reg == 2'h2) begin
                            state_reg <= scan_net_pkg::ST_PICK;
                        end
                    end
                end
                scan_net_pkg::ST_CFG_HDR: begin
                    if (!cfg_ok) begin
                        state_reg <= scan_net_pkg::ST_CFG_DATA;
                    end else if (bus_free) begin
                        bus_tx_reg <= '{valid: 1'b1, data: mk_req(`CMD_CFG, host_cfg.addr)};
                        bus_de_reg <= 1'b1;
                        state_reg <= scan_net_pkg::ST_CFG_DATA;
                    end
                end
                scan_net_pkg::ST_CFG_DATA: begin
                    // Bytes for an unreachable slave are taken and dropped.
                    if (cfg_byte) begin
                        cfg_take_reg <= 1'b1;
                        if (bus_de_reg) begin
                            bus_tx_reg <= '{valid: 1'b1, data: host_cfg.data};
                        end
                        if (host_cfg.last && bus_de_reg) begin
                            // Poll the target next so that its answer reaches the host.
                            cur_addr_reg <= host_cfg.addr;
                            state_reg <= scan_net_pkg::ST_SEND;
                        end else if (host_cfg.last) begin
                            state_reg <= scan_net_pkg::ST_PICK;
                        end
                    end
                end
                default: begin
                    state_reg <= scan_net_pkg::ST_PICK;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign bus_tx = bus_tx_reg;
    assign bus_drive_en = bus_de_reg;
    assign host_tx = host_tx_reg;
    assign cfg_take = cfg_take_reg;
    assign init_done = init_done_reg;
    assign alive_map = alive_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset || !clk_en);

    sequence s_silent;
        state_reg == scan_net_pkg::ST_WAIT && timed_out;
    endsequence

    sequence s_found;
        state_reg == scan_net_pkg::ST_WAIT && !init_done_reg && bus_rx.valid && bus_rx.last;
    endsequence

    a_req_addr_range: assert property (
        state_reg == scan_net_pkg::ST_SEND |-> cur_addr_reg != `MASTER_ADDR
            && cur_addr_reg <= last_addr)
        else $error("Request addressed outside one to highest slave.");

    a_init_cmd: assert property (
        bus_tx_reg.valid && state_reg == scan_net_pkg::ST_SEND && !init_done_reg
            |-> bus_tx_reg.data[7:5] == `CMD_INIT)
        else $error("Search phase sent a request that is not a search.");

    a_dead_skip: assert property (
        state_reg == scan_net_pkg::ST_SEND && init_done_reg |-> alive_reg[cur_addr_reg])
        else $error("Unreachable slave was polled.");

    a_timeout_report: assert property (
        s_silent |=> state_reg == scan_net_pkg::ST_REPORT && !rpt_ok_reg
            && !alive_reg[cur_addr_reg])
        else $error("Timeout not reported.");

    a_found_report: assert property (
        s_found |=> state_reg == scan_net_pkg::ST_REPORT && rpt_ok_reg)
        else $error("Found slave not reported.");

    a_report_letter: assert property (
        state_reg == scan_net_pkg::ST_REPORT && rpt_idx_reg == 2'h2 && host_free
            |=> host_tx_reg.valid && host_tx_reg.data == ($past(rpt_ok_reg) ? `CHR_S : `CHR_T))
        else $error("Report letter wrong.");

    a_forward_data: assert property (
        state_reg == scan_net_pkg::ST_WAIT && init_done_reg && bus_rx.valid && host_free
            |=> host_tx_reg.valid && host_tx_reg.data == $past(bus_rx.data))
        else $error("Slave byte not forwarded to host.");

    a_bus_quiet: assert property (
        state_reg == scan_net_pkg::ST_WAIT ##1 state_reg == scan_net_pkg::ST_WAIT
            |-> !bus_de_reg)
        else $error("Bus driven while waiting for a slave.");

    a_wait_bound: assert property (
        state_reg == scan_net_pkg::ST_WAIT |-> timer_reg <= resp_wait)
        else $error("Response wait overran its limit.");

    a_search_end: assert property (
        $rose(init_done_reg) |-> cur_addr_reg >= last_addr)
        else $error("Search ended before the highest slave.");

endmodule : scan_net_master

`default_nettype wire

// ### slave_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "scan_net_defs.svh"

module slave_model (
    // Clock
    input wire logic sys_clk,
    // Shared bus, byte level
    input wire scan_net_pkg::byte_flow_t bus_tx,
    output logic bus_tx_ready,
    input wire logic bus_drive_en,
    output var scan_net_pkg::rx_flow_t bus_rx,
    // Control from the bench
    input wire logic [31:0] present,
    input wire logic slow
);
    logic toggle_reg = 1'h0;
    logic [7:0] req;

    always_ff @(posedge sys_clk) toggle_reg <= ~toggle_reg;
    assign bus_tx_ready = ~slow | toggle_reg;

    // An idle receive byte carries the inverse of the last one, so stale data never matches.
    task automatic send(input logic [7:0] d, input logic lst);
        @(posedge sys_clk);
        bus_rx <= '{valid: 1'h1, last: lst, data: d};
        @(posedge sys_clk);
        bus_rx <= '{valid: 1'h0, last: 1'h0, data: ~d};
    endtask : send

    initial begin
        bus_rx = '0;
        forever begin
            @(posedge sys_clk);
            req = bus_tx.data;
            if (bus_tx.valid && bus_tx_ready && req[4:0] != 5'h00 && present[req[4:0]]
                && (req[7:5] == `CMD_INIT || req[7:5] == `CMD_POLL)) begin
                // Answering while the master still drives the pair would collide.
                while (bus_drive_en) @(posedge sys_clk);
                if (req[7:5] == `CMD_POLL) send(8'hA0 | {3'h0, req[4:0]}, 1'h0);
                send(8'h0D, 1'h1);
            end
        end
    end
endmodule : slave_model

`default_nettype wire

// ### tb_polled_scanner_network_master.sv
`timescale 1ns/10ps
`default_nettype none
`include "scan_net_defs.svh"

module tb_polled_scanner_network_master;
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic clk_en = 1'h1;
    logic [`ADDR_W-1:0] last_addr = 5'h04;
    logic [`TMO_W-1:0] resp_wait = 16'h0014;
    scan_net_pkg::byte_flow_t bus_tx;
    scan_net_pkg::byte_flow_t host_tx;
    scan_net_pkg::rx_flow_t bus_rx;
    scan_net_pkg::cfg_flow_t host_cfg = '0;
    logic bus_tx_ready;
    logic bus_drive_en;
    logic host_tx_ready = 1'h1;
    logic cfg_take;
    logic init_done;
    logic [31:0] alive_map;
    logic [31:0] present = 32'h0000_0016;
    logic slow = 1'h0;
    int num_errors = 0;
    int compares = 0;
    logic [7:0] host_q[$];
    logic [7:0] bus_q[$];

    scan_net_master dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .last_addr(last_addr), .resp_wait(resp_wait), .bus_tx(bus_tx),
        .bus_tx_ready(bus_tx_ready), .bus_drive_en(bus_drive_en), .bus_rx(bus_rx),
        .host_tx(host_tx), .host_tx_ready(host_tx_ready), .host_cfg(host_cfg),
        .cfg_take(cfg_take), .init_done(init_done), .alive_map(alive_map));
    slave_model slaves (.sys_clk(sys_clk), .bus_tx(bus_tx), .bus_tx_ready(bus_tx_ready),
        .bus_drive_en(bus_drive_en), .bus_rx(bus_rx), .present(present), .slow(slow));

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task complete_run;
        $display("comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    task pop(input bit from_bus, output logic [7:0] b);
        int n;
        n = 0;
        while ((from_bus ? bus_q.size() : host_q.size()) == 0 && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
        b = 8'h00;
        if ((from_bus ? bus_q.size() : host_q.size()) == 0) check(32'h0, 32'h1, "byte missing");
        else b = from_bus ? bus_q.pop_front() : host_q.pop_front();
    endtask : pop

    task expect_report(input int a, input logic [7:0] code);
        logic [7:0] b;
        pop(1'b0, b);
        check(b, 8'(8'h30 + a / 10), "tens digit");
        pop(1'b0, b);
        check(b, 8'(8'h30 + a % 10), "ones digit");
        pop(1'b0, b);
        check(b, code, "report letter");
    endtask : expect_report

    task send_cfg(input logic [4:0] a);
        int n;
        n = 0;
        @(posedge sys_clk);
        host_cfg <= '{valid: 1'h1, last: 1'h1, addr: a, data: 8'h1F};
        @(posedge sys_clk);
        while (!cfg_take && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
        check(cfg_take, 1'h1, "config byte taken");
        host_cfg <= '0;
    endtask : send_cfg

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task test_search;
        logic [7:0] b;
        int n;
        for (int a = 1; a <= 4; a++) expect_report(a, present[a] ? 8'h53 : 8'h54);
        n = 0;
        while (!init_done && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        check(init_done, 1'h1, "search finished");
        check(alive_map, 32'h0000_0016, "alive map");
        for (int a = 1; a <= 4; a++) begin
            pop(1'b1, b);
            check(b, {3'h1, 5'(a)}, "search request");
        end
        $display("test search done");
    endtask : test_search

    task test_poll;
        logic [7:0] b;
        for (int a = 1; a <= 4; a++) begin
            if (a != 3) begin
                pop(1'b1, b);
                check(b, {3'h2, 5'(a)}, "poll request");
                pop(1'b0, b);
                check(b, 8'(8'hA0 + a), "forwarded data");
                pop(1'b0, b);
                check(b, 8'h0D, "forwarded end");
            end
        end
        $display("test poll done");
    endtask : test_poll

    task test_config;
        logic [7:0] b;
        bit seen_dead;
        int n;
        slow <= 1'h1;
        send_cfg(5'h03);
        send_cfg(5'h02);
        seen_dead = 1'b0;
        n = 0;
        b = 8'h00;
        while (b !== 8'h62 && n < 100) begin
            pop(1'b1, b);
            if (b === 8'h63) seen_dead = 1'b1;
            n++;
        end
        check(b, 8'h62, "config header");
        check(seen_dead, 1'h0, "config to lost station");
        pop(1'b1, b);
        check(b, 8'h1F, "config data");
        pop(1'b1, b);
        check(b, 8'h42, "poll after config");
        slow <= 1'h0;
        $display("test config done");
    endtask : test_config

    task test_lost;
        logic [7:0] b;
        logic [7:0] p1;
        logic [7:0] p2;
        int n;
        present <= 32'h0000_0006;
        b = 8'h00;
        p1 = 8'h00;
        p2 = 8'h00;
        n = 0;
        while (b !== 8'h54 && n < 400) begin
            p1 = p2;
            p2 = b;
            pop(1'b0, b);
            n++;
        end
        check({8'h00, p1, p2, b}, 32'h0030_3454, "lost station report");
        repeat (4) @(posedge sys_clk);
        check(alive_map, 32'h0000_0006, "alive map after loss");
        $display("test lost done");
    endtask : test_lost

    // ------------------------------------------------------------
    // Clock, monitor, watchdog and main sequence
    // ------------------------------------------------------------
    initial forever #2.5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (host_tx.valid && host_tx_ready) host_q.push_back(host_tx.data);
        if (bus_tx.valid && bus_tx_ready) begin
            bus_q.push_back(bus_tx.data);
            check(bus_drive_en, 1'h1, "drive enable while sending");
        end
    end

    // The whole run needs a few hundred cycles; this leaves ample margin.
    initial begin
        repeat (40000) @(posedge sys_clk);
        num_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'h0;
        test_search();
        test_poll();
        test_config();
        test_lost();
        complete_run();
    end
endmodule : tb_polled_scanner_network_master

`default_nettype wire
